// [hdl/dps_pkg.sv]
// package for the dual slot power sequencer
package dps_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    // power-on-reset interval, microseconds
    localparam int unsigned POR_TIME_US = 250;
    // no rounding up; a zero count is raised to one cycle
    localparam int unsigned POR_CYCLES = (POR_TIME_US * (CLK_HZ / 1000000) + 0) == 0 ? 1 :
        POR_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned POR_CW = 12;
    localparam logic [POR_CW-1:0] POR_LOAD = POR_CW'(POR_CYCLES - 1);
    // nominal gate current, microamps (analog, carried for reference)
    localparam int unsigned GATE_CURRENT_UA = 25;
    localparam logic [1:0] RESET_BITS = 2'h0;
    // slot outputs after reset: pull-up, pull-down and both discharges on, fault released
    localparam logic [7:0] SLOT_OFF = 8'ha7;

    typedef enum logic [1:0] {
        DPS_POR  = 2'b00,
        DPS_RUN  = 2'b01
    } dps_phase_t;

    // per-slot controls from the host side
    typedef struct packed {
        logic main_enable_pin;
        logic aux_slot_enable_pin;
        logic main_enable_bit;
        logic aux_enable_bit;
    } dps_slot_ctl_t;

    // per-slot drive outputs
    typedef struct packed {
        logic gate_drive_12v_pullup;
        logic gate_drive_12v_sink;
        logic gate_drive_3v3_pulldown;
        logic gate_drive_3v3_source;
        logic aux_power_output;
        logic main_discharge;
        logic aux_discharge;
        logic fault_n;
    } dps_slot_out_t;

    typedef struct packed {
        dps_phase_t phase;
        logic [POR_CW-1:0] por_count;
        logic mgmt_ready;
        logic standby;
        logic [1:0] main_on;
        logic [1:0] aux_on;
        logic [1:0] fault;
        logic int_n;
        dps_slot_out_t [1:0] slot;
    } dps_state_t;
endpackage

// [hdl/dps_sequencer.sv]
// power-on-reset, gate drive, aux and standby sequencing for two slots
// Overview of operation
// - start reset interval when standby supply valid; end after 250 us valid
// - all internal state is held at defaults from the start of the reset interval until it completes
// - standby supply dropout restarts a full reset interval
// - management bus refused until the reset interval has ended
// - all slot outputs held off during the reset interval
// - main off: 12 V gate pulled high, 3.3 V gate pulled low
// - main enable: both gates constant current, source on 3.3 V, sink on 12 V
// - disabling main or aux connects discharge resistance to affected outputs
// - standby mode whenever either main supply input is under lockout
// - aux output follows aux pin or aux bit, independent of mains
// - enabled aux keeps running in standby while standby supply present
// - main enabled at main undervoltage raises slot fault and maybe interrupt
// - interrupt deasserts once writing one has cleared every set fault bit
`timescale 1ns/1ps
module dps_sequencer (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // supply monitors, high when above lockout level
    input wire logic standby_supply_in,
    input wire logic main_12v_valid,
    input wire logic main_3v3_valid,
    // per-slot enables from pins and control bits
    input wire dps_pkg::dps_slot_ctl_t [1:0] slot_ctl,
    // interrupt enable and write-one-to-clear fault strobe per slot
    input wire logic int_enable,
    input wire logic [1:0] fault_clear,
    // status
    output logic mgmt_ready,
    output logic standby_mode,
    output logic int_n,
    output dps_pkg::dps_slot_out_t [1:0] slot_out
);
    dps_pkg::dps_state_t st;
    dps_pkg::dps_state_t next_st;
    logic [1:0] main_req;
    logic [1:0] aux_req;
    logic [1:0] uv_fault;
    logic main_uv;

    // default state: everything off, gates at off levels
    function automatic dps_pkg::dps_state_t dflt();
        dps_pkg::dps_state_t d;
        d = '0;
        d.phase = dps_pkg::DPS_POR;
        d.por_count = dps_pkg::POR_LOAD;
        d.int_n = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            d.slot[i].gate_drive_12v_pullup = 1'b1;
            d.slot[i].gate_drive_3v3_pulldown = 1'b1;
            d.slot[i].main_discharge = 1'b1;
            d.slot[i].aux_discharge = 1'b1;
            d.slot[i].fault_n = 1'b1;
        end
        return d;
    endfunction

    always_comb
    begin
        main_uv = !(main_12v_valid && main_3v3_valid);
        for (int i = 0; i < 2; i++)
        begin
            main_req[i] = slot_ctl[i].main_enable_pin || slot_ctl[i].main_enable_bit;
            aux_req[i] = slot_ctl[i].aux_slot_enable_pin || slot_ctl[i].aux_enable_bit;
            uv_fault[i] = main_req[i] && main_uv;
        end
    end

    // one state update; the reset interval forces defaults, so no stale bits
    always_comb
    begin
        next_st = st;
        if (!standby_supply_in)
        begin
            next_st = dflt();
        end
        else
        begin
            unique case (st.phase)
                dps_pkg::DPS_POR:
                begin
                    next_st = dflt();
                    if (st.por_count == '0)
                    begin
                        next_st.phase = dps_pkg::DPS_RUN;
                        next_st.mgmt_ready = 1'b1;
                    end
                    else
                    begin
                        next_st.por_count = st.por_count - 1'b1;
                    end
                end
                dps_pkg::DPS_RUN:
                begin
                    next_st.standby = main_uv;
                    for (int i = 0; i < 2; i++)
                    begin
                        // set wins over a clear in the same cycle
                        if (uv_fault[i])
                            next_st.fault[i] = 1'b1;
                        else if (fault_clear[i])
                            next_st.fault[i] = 1'b0;
                        // mains only on with inputs valid and no trip latched
                        next_st.main_on[i] = main_req[i] && !main_uv && !next_st.fault[i];
                        next_st.aux_on[i] = aux_req[i];
                        next_st.slot[i].gate_drive_12v_pullup = !next_st.main_on[i];
                        next_st.slot[i].gate_drive_3v3_pulldown = !next_st.main_on[i];
                        next_st.slot[i].gate_drive_12v_sink = next_st.main_on[i];
                        next_st.slot[i].gate_drive_3v3_source = next_st.main_on[i];
                        next_st.slot[i].main_discharge = !next_st.main_on[i];
                        next_st.slot[i].aux_power_output = next_st.aux_on[i];
                        next_st.slot[i].aux_discharge = !next_st.aux_on[i];
                        next_st.slot[i].fault_n = !next_st.fault[i];
                    end
                    next_st.int_n = !(int_enable && (next_st.fault != 2'h0));
                end
                default:
                begin
                    next_st = dflt();
                end
            endcase
        end
    end

    // single register for all state
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            st <= '{phase: dps_pkg::DPS_POR, por_count: dps_pkg::POR_LOAD, mgmt_ready: 1'b0,
                    standby: 1'b0, main_on: 2'h0, aux_on: 2'h0, fault: 2'h0, int_n: 1'b1,
                    slot: {2{dps_pkg::SLOT_OFF}}};
        else
            st <= next_st;
    end

    assign mgmt_ready = st.mgmt_ready;
    assign standby_mode = st.standby;
    assign int_n = st.int_n;
    assign slot_out = st.slot;

    // reset interval count of cycles from valid to ready
    logic [12:0] ast_valid_cnt;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ast_valid_cnt <= 13'h0;
        else if (!standby_supply_in)
            ast_valid_cnt <= 13'h0;
        else if (ast_valid_cnt != 13'h1fff)
            ast_valid_cnt <= ast_valid_cnt + 13'h1;
    end

    // rule checks on the rising edge; helper count is kept apart from the design's own
    AST_POR_LEN: assert property (@(posedge clock) disable iff (!rstn)
        $rose(mgmt_ready) |-> ast_valid_cnt == 13'(dps_pkg::POR_CYCLES))
        else $error("ready not after full reset interval");
    AST_READY_AT_END: assert property (@(posedge clock) disable iff (!rstn)
        ast_valid_cnt == 13'(dps_pkg::POR_CYCLES) |-> mgmt_ready)
        else $error("ready missing at end of reset interval");
    AST_NO_BUS_EARLY: assert property (@(posedge clock) disable iff (!rstn)
        (ast_valid_cnt < 13'(dps_pkg::POR_CYCLES)) |-> !mgmt_ready)
        else $error("bus ready during reset interval");
    AST_RESTART: assert property (@(posedge clock) disable iff (!rstn)
        !standby_supply_in |=> !mgmt_ready && st.fault == 2'h0)
        else $error("dropout did not restart");
    AST_OFF_IN_POR: assert property (@(posedge clock) disable iff (!rstn)
        !mgmt_ready |-> !slot_out[0].aux_power_output && !slot_out[1].aux_power_output
            && !slot_out[0].gate_drive_12v_sink && !slot_out[1].gate_drive_12v_sink
            && !slot_out[0].gate_drive_3v3_source && !slot_out[1].gate_drive_3v3_source)
        else $error("output on during reset interval");
    AST_GATE_OFF: assert property (@(posedge clock) disable iff (!rstn)
        !slot_out[0].gate_drive_3v3_source |-> slot_out[0].gate_drive_12v_pullup
            && slot_out[0].gate_drive_3v3_pulldown)
        else $error("gate off levels wrong");
    AST_GATE_ON: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && slot_ctl[1].main_enable_pin && main_12v_valid && main_3v3_valid
            && standby_supply_in && !st.fault[1] && !fault_clear[1] |=>
            slot_out[1].gate_drive_12v_sink && slot_out[1].gate_drive_3v3_source)
        else $error("gate not switched to current mode");
    // slot 0 main discharge must connect and its 12 V sink release once the main enable drops
    AST_MAIN_DISCHARGE: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && !main_req[0] |=>
            slot_out[0].main_discharge && !slot_out[0].gate_drive_12v_sink)
        else $error("main discharge not connected");
    AST_AUX: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && aux_req[1] |=>
            slot_out[1].aux_power_output && !slot_out[1].aux_discharge)
        else $error("aux not on from pin or bit");
    AST_AUX_STANDBY: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && main_uv && aux_req[0] |=>
            slot_out[0].aux_power_output)
        else $error("aux dropped in standby");
    AST_STANDBY: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && main_uv |=> standby_mode)
        else $error("standby mode not entered");
    AST_UV_FAULT: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && main_uv && main_req[0]
            && int_enable |=> !slot_out[0].fault_n && !int_n)
        else $error("undervoltage fault missing");
    // a trip in the same cycle as its clear must stick
    AST_SET_WINS: assert property (@(posedge clock) disable iff (!rstn)
        mgmt_ready && standby_supply_in && uv_fault[0] && fault_clear[0]
            |=> !slot_out[0].fault_n)
        else $error("clear beat a new fault");
    AST_INT_MASKED: assert property (@(posedge clock) disable iff (!rstn)
        !int_enable |=> int_n)
        else $error("interrupt raised while masked");
    AST_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
        standby_supply_in && !main_uv && fault_clear[0] && (fault_clear[1] || !st.fault[1])
            |=> int_n && slot_out[0].fault_n)
        else $error("interrupt not cleared");

    // main scenarios the bench has to reach
    COV_READY: cover property (@(posedge clock) disable iff (!rstn) $rose(mgmt_ready));
    COV_SET_WINS: cover property (@(posedge clock) disable iff (!rstn)
        uv_fault[0] && fault_clear[0]);
    COV_MAIN_ON: cover property (@(posedge clock) disable iff (!rstn)
        $rose(slot_out[0].gate_drive_12v_sink));
    COV_FAULT: cover property (@(posedge clock) disable iff (!rstn) $fell(int_n));
    COV_STANDBY_AUX: cover property (@(posedge clock) disable iff (!rstn)
        standby_mode && slot_out[0].aux_power_output);
endmodule

// [dv/dps_host_model.sv]
// host side model: hot-plug controller plus management bus host, both slots
`timescale 1ns/1ps
module dps_host_model (
    // path select, high picks the control bits over the pins
    input wire logic use_bus,
    // per-slot power requests from the bench
    input wire logic [1:0] main_req,
    input wire logic [1:0] aux_req,
    // drive into the sequencer
    output dps_pkg::dps_slot_ctl_t [1:0] slot_ctl
);
    // only one power path is ever used; the idle path sits at its off level
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            slot_ctl[i].main_enable_pin = main_req[i] & ~use_bus;
            slot_ctl[i].aux_slot_enable_pin = aux_req[i] & ~use_bus;
            slot_ctl[i].main_enable_bit = main_req[i] & use_bus;
            slot_ctl[i].aux_enable_bit = aux_req[i] & use_bus;
        end
    end
endmodule

// [dv/dual_slot_power_sequencer_test.sv]
// self-checking bench for the dual slot power sequencer
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module dual_slot_power_sequencer_test;
    logic clock, rstn, standby_supply_in, main_12v_valid, main_3v3_valid;
    logic use_bus, int_enable, mgmt_ready, standby_mode, int_n;
    logic [1:0] main_req, aux_req, fault_clear;
    dps_pkg::dps_slot_ctl_t [1:0] slot_ctl;
    dps_pkg::dps_slot_out_t [1:0] slot_out;
    int bad_count, samples_checked;
    // host model and sequencer
    dps_host_model host (.use_bus(use_bus), .main_req(main_req), .aux_req(aux_req),
        .slot_ctl(slot_ctl));
    dps_sequencer DUT (.clock(clock), .rstn(rstn), .standby_supply_in(standby_supply_in),
        .main_12v_valid(main_12v_valid), .main_3v3_valid(main_3v3_valid), .slot_ctl(slot_ctl),
        .int_enable(int_enable), .fault_clear(fault_clear), .mgmt_ready(mgmt_ready),
        .standby_mode(standby_mode), .int_n(int_n), .slot_out(slot_out));
    // 10 MHz clock
    always #50 clock = ~clock;
    task step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // standby supply became valid just before the next edge; enables held high until the last cycle of the interval
    task por_wait;
        step(dps_pkg::POR_CYCLES - 1);
        `CHK("ready early", 1'b0, mgmt_ready)
        `CHK("outs in interval", 16'ha7a7, slot_out)
        main_req = 2'b00;
        aux_req = 2'b00;
        step(1);
        `CHK("ready", 1'b1, mgmt_ready)
        step(1);
        `CHK("outs after interval", 16'ha7a7, slot_out)
    endtask
    task t_main;
        main_req = 2'b01;
        step(1);
        `CHK("slot a on, b off", 16'ha753, slot_out)
        main_req = 2'b10;
        step(1);
        `CHK("a discharged, b on", 16'h53a7, slot_out)
        use_bus = 1'b1;
        main_req = 2'b01;
        step(1);
        `CHK("bus a on", 16'ha753, slot_out)
        main_req = 2'b00;
        step(1);
        $display("main gate test done");
    endtask
    task t_aux;
        aux_req = 2'b10;
        step(1);
        `CHK("aux b by bit", 16'hada7, slot_out)
        use_bus = 1'b0;
        aux_req = 2'b01;
        main_3v3_valid = 1'b0; // mains already dropped, as the host should
        step(1);
        `CHK("aux a by pin", 16'ha7ad, slot_out)
        `CHK("standby", 1'b1, standby_mode)
        main_3v3_valid = 1'b1;
        aux_req = 2'b00;
        step(1);
        `CHK("standby left", 1'b0, standby_mode)
        $display("aux and standby test done");
    endtask
    task t_fault;
        int_enable = 1'b1;
        main_req = 2'b01;
        step(1);
        main_12v_valid = 1'b0;
        step(1);
        `CHK("uv fault a", 16'ha7a6, slot_out)
        `CHK("uv int", 1'b0, int_n)
        main_req = 2'b00;
        main_12v_valid = 1'b1;
        step(2);
        `CHK("fault held", 1'b0, int_n)
        fault_clear = 2'b01;
        step(1);
        `CHK("fault cleared", 16'ha7a7, slot_out)
        `CHK("int released", 1'b1, int_n)
        // trip and clear in one cycle: the trip must stick
        main_req = 2'b01;
        main_3v3_valid = 1'b0;
        step(1);
        `CHK("set beats clear", 1'b0, int_n)
        `CHK("standby in uv", 1'b1, standby_mode)
        main_req = 2'b00;
        main_3v3_valid = 1'b1;
        step(1);
        `CHK("late clear", 16'ha7a7, slot_out)
        // masked interrupt: fault pin only
        fault_clear = 2'b00;
        int_enable = 1'b0;
        main_req = 2'b10;
        main_12v_valid = 1'b0;
        step(1);
        `CHK("masked fault b", 16'ha6a7, slot_out)
        `CHK("masked int", 1'b1, int_n)
        main_req = 2'b00;
        main_12v_valid = 1'b1;
        fault_clear = 2'b10;
        step(1);
        `CHK("fault b cleared", 16'ha7a7, slot_out)
        fault_clear = 2'b00;
        $display("undervoltage fault test done");
    endtask
    task t_restart;
        aux_req = 2'b11;
        step(2);
        `CHK("both aux", 16'hadad, slot_out)
        standby_supply_in = 1'b0;
        step(1);
        `CHK("dropout ready", 1'b0, mgmt_ready)
        `CHK("dropout outs", 16'ha7a7, slot_out)
        standby_supply_in = 1'b1;
        step(1000);
        `CHK("mid interval", 1'b0, mgmt_ready)
        standby_supply_in = 1'b0;
        step(1);
        standby_supply_in = 1'b1;
        main_req = 2'b11;
        aux_req = 2'b11;
        por_wait();
        $display("restart test done");
    endtask
    // bench drives on the falling edge
    initial
    begin
        clock = 1'b0;
        rstn = 1'b0;
        standby_supply_in = 1'b1;
        main_12v_valid = 1'b1;
        main_3v3_valid = 1'b1;
        use_bus = 1'b0;
        main_req = 2'b11;
        aux_req = 2'b11;
        int_enable = 1'b0;
        fault_clear = 2'b00;
        bad_count = 0;
        samples_checked = 0;
        step(20);
        rstn = 1'b1;
        por_wait();
        $display("reset interval test done");
        t_main();
        t_aux();
        t_fault();
        t_restart();
        final_report();
    end
    // watchdog: whole run is under 7000 cycles
    initial
    begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule
